// [rtl/bms_params.svh]
// constants for the banked memory and return stack block
// assumes inclusion by bare name from rtl files
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
// core register offsets within every bank
`define BMS_OFS_IND0 7'h00
`define BMS_OFS_IND1 7'h01
`define BMS_OFS_PCL 7'h02
`define BMS_OFS_STATUS 7'h03
`define BMS_OFS_P0L 7'h04
`define BMS_OFS_P0H 7'h05
`define BMS_OFS_P1L 7'h06
`define BMS_OFS_P1H 7'h07
`define BMS_OFS_BANK 7'h08
`define BMS_OFS_WORK 7'h09
`define BMS_OFS_PCLATCH 7'h0a
`define BMS_OFS_INTCTL 7'h0b
`define BMS_OFS_CORE_LAST 7'h0b
// stack access registers, bank 31 (chosen offsets)
`define BMS_STK_BANK 5'h1f
`define BMS_OFS_TOS_LOW 7'h6e
`define BMS_OFS_TOS_HIGH 7'h6f
`define BMS_OFS_STK_PTR 7'h6d
// area boundaries inside a bank
`define BMS_OFS_GPR_FIRST 7'h20
`define BMS_OFS_COMMON_FIRST 7'h70
// pointer high byte bit selecting program memory
`define BMS_PROG_SEL_BIT 7
// empty stack pointer value
`define BMS_STK_EMPTY 5'h1f
// reset values
`define BMS_RST_BYTE 8'h00
`endif

// [rtl/bms_pkg.sv]
// types for the banked memory and return stack block
// assumes nothing outside itself
package bms_pkg;
  // access sequencing states, gray along the path
  typedef enum logic [1:0] {
    BMS_IDLE = 2'b00,
    BMS_PROG_WAIT = 2'b01
  } bms_state_t;
  // stack operations requested by the core
  typedef enum logic [1:0] {
    BMS_STK_NONE = 2'b00,
    BMS_STK_PUSH = 2'b01,
    BMS_STK_POP = 2'b11
  } bms_stk_op_t;
endpackage : bms_pkg

// [rtl/bms_return_stack.sv]
// hardware return stack with software visible pointer
// assumes one push or pop per cycle from the execution core
`timescale 1ns/1ps
`include "bms_params.svh"
module bms_return_stack
  import bms_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
)(
  input wire logic sys_clk, // core clock
  input wire logic arst_n, // async reset, low
  input wire logic dev_rst, // synchronous device reset
  input wire bms_stk_op_t op, // push or pop
  input wire logic [WIDTH-1:0] push_pc, // pc to push
  input wire logic fault_rst_en, // stack fault reset enable
  input wire logic ptr_we, // software pointer write
  input wire logic [4:0] ptr_wdata, // new pointer value
  input wire logic tos_we_low, // top of stack low write
  input wire logic tos_we_high, // top of stack high write
  input wire logic [7:0] tos_wdata, // top of stack write data
  output logic [4:0] ptr, // stack pointer
  output logic [WIDTH-1:0] tos, // entry at pointer
  output logic ovf_evt, // overflow pulse
  output logic unf_evt, // underflow pulse
  output logic fault_rst // stack fault reset request
);
  // refuse shapes the pointer logic cannot serve
  if (DEPTH != 16 || WIDTH != 15)
  begin : g_bad_shape
    $error("stack must be 16 x 15");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [4:0] ptr_r;
  logic [4:0] ptr_nxt;
  logic [3:0] idx;
  logic ovf;
  logic unf;
  assign ptr = ptr_r;
  assign idx = ptr_r[3:0];
  assign tos = mem[idx];
  // push past level 16 or pop below level 1
  assign ovf = (op == BMS_STK_PUSH) && (ptr_r == 5'h0f);
  assign unf = (op == BMS_STK_POP) && (ptr_r == `BMS_STK_EMPTY);
  assign ovf_evt = ovf;
  assign unf_evt = unf;
  assign fault_rst = fault_rst_en && (ovf || unf);
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (ptr_we)
      ptr_nxt = ptr_wdata;
    else if (op == BMS_STK_PUSH)
      ptr_nxt = ptr_r + 5'h01;
    else if (op == BMS_STK_POP)
      ptr_nxt = ptr_r - 5'h01;
  end
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ptr_r <= `BMS_STK_EMPTY;
    else if (dev_rst)
      ptr_r <= `BMS_STK_EMPTY;
    else if (ptr_nxt == `BMS_STK_EMPTY)
      ptr_r <= `BMS_STK_EMPTY;
    else
      ptr_r <= {1'b0, ptr_nxt[3:0]};
  end
  always_ff @(posedge sys_clk)
  begin
    if (op == BMS_STK_PUSH && !dev_rst)
      mem[ptr_nxt[3:0]] <= push_pc;
    else if (tos_we_low)
      mem[idx] <= {mem[idx][WIDTH-1:8], tos_wdata};
    else if (tos_we_high)
      mem[idx] <= {tos_wdata[WIDTH-9:0], mem[idx][7:0]};
  end
endmodule : bms_return_stack

// [rtl/bms_core_mem.sv]
// banked data memory decode, indirect access and return stack
// assumes the execution core gives one access per request
`timescale 1ns/1ps
`include "bms_params.svh"
// ==========================================================
module bms_core_mem
  import bms_pkg::*;
#(
  parameter int GPR_BYTES = 80,
  parameter int COMMON_BYTES = 16,
  parameter int BANKS = 32
)(
  input wire logic sys_clk, // core clock
  input wire logic arst_n, // async reset, low
  input wire logic req, // access request
  input wire logic indirect, // access through pointer
  input wire logic ptr_sel, // which pointer
  input wire logic [6:0] dir_ofs, // direct offset
  input wire logic we, // write access
  input wire logic [7:0] wdata, // write data
  output logic ack, // access done
  output logic [7:0] rdata, // read data
  output logic prog_req, // program memory fetch
  output logic [14:0] prog_addr, // program word address
  input wire logic [13:0] prog_word, // program word
  input wire logic call_push, // call or interrupt
  input wire logic ret_pop, // any return
  input wire logic [14:0] pc_in, // pc to push
  output logic [14:0] pc_ret, // popped pc
  output logic [7:0] pc_upper_latch, // upper latch
  output logic [7:0] working_value, // working reg
  output logic [7:0] interrupt_control, // interrupt ctl
  input wire logic stack_fault_reset_enable, // config bit
  input wire logic flag_clr_ovf, // software clear
  input wire logic flag_clr_unf, // software clear
  output logic stack_overflow_flag, // power ctl flag
  output logic stack_underflow_flag, // power ctl flag
  output logic dev_reset_req // reset on stack fault
);
  // refuse memory shapes the decode cannot serve
  if (BANKS != 32 || GPR_BYTES > 80 || COMMON_BYTES != 16)
  begin : g_bad_shape
    $error("unsupported memory shape");
  end
  // ========================================================
  // core registers
  logic [7:0] p0l_r, p0h_r, p1l_r, p1h_r, bank_r, work_r;
  logic [7:0] pc_upper_latch_r, intctl_r, status_r, pcl_r;
  logic ovf_r, unf_r, dev_rst_r;
  bms_state_t st_r;
  logic [11:0] addr;
  logic [6:0] ofs;
  logic [4:0] bank;
  logic prog;
  logic [15:0] pptr;
  logic [7:0] mem_rd;
  logic [7:0] rd_nxt;
  logic wr;
  logic [4:0] sp;
  logic [14:0] tos;
  logic ovf_e, unf_e, frst;
  bms_stk_op_t op;
  assign working_value = work_r;
  assign pc_upper_latch = pc_upper_latch_r;
  assign interrupt_control = intctl_r;
  assign stack_overflow_flag = ovf_r;
  assign stack_underflow_flag = unf_r;
  assign dev_reset_req = dev_rst_r;
  assign pptr = ptr_sel ? {p1h_r, p1l_r} : {p0h_r, p0l_r};
  assign prog = indirect && pptr[`BMS_PROG_SEL_BIT + 8];
  assign prog_addr = pptr[14:0];
  assign addr = indirect ? pptr[11:0] : {bank_r[4:0], dir_ofs};
  assign bank = addr[11:7];
  assign ofs = addr[6:0];
  assign wr = req && we && !prog;
  // ========================================================
  // general and common ram
  // banks of 128 bytes
  // per bank general area and shared common area
  logic [7:0] general_purpose_ram [BANKS][GPR_BYTES];
  logic [7:0] common [COMMON_BYTES];
  logic gpr_hit, com_hit;
  assign gpr_hit = ofs >= `BMS_OFS_GPR_FIRST &&
    ofs < (`BMS_OFS_GPR_FIRST + 7'(GPR_BYTES));
  assign com_hit = ofs >= `BMS_OFS_COMMON_FIRST;
  assign mem_rd = gpr_hit ? general_purpose_ram[bank][ofs - `BMS_OFS_GPR_FIRST] :
    com_hit ? common[ofs[3:0]] : `BMS_RST_BYTE;
  // ram writes
  always_ff @(posedge sys_clk)
  begin
    if (wr && gpr_hit)
      general_purpose_ram[bank][ofs - `BMS_OFS_GPR_FIRST] <= wdata;
    if (wr && com_hit)
      common[ofs[3:0]] <= wdata;
  end
  // ========================================================
  // read mux
  // core registers mirrored in all banks
  always_comb
  begin
    rd_nxt = mem_rd;
    if (ofs <= `BMS_OFS_CORE_LAST)
    begin
      case (ofs)
        `BMS_OFS_PCL: rd_nxt = pcl_r;
        `BMS_OFS_STATUS: rd_nxt = status_r;
        `BMS_OFS_P0L: rd_nxt = p0l_r;
        `BMS_OFS_P0H: rd_nxt = p0h_r;
        `BMS_OFS_P1L: rd_nxt = p1l_r;
        `BMS_OFS_P1H: rd_nxt = p1h_r;
        `BMS_OFS_BANK: rd_nxt = bank_r;
        `BMS_OFS_WORK: rd_nxt = work_r;
        `BMS_OFS_PCLATCH: rd_nxt = pc_upper_latch_r;
        `BMS_OFS_INTCTL: rd_nxt = intctl_r;
        default: rd_nxt = `BMS_RST_BYTE;
      endcase
    end
    else if (bank == `BMS_STK_BANK)
    begin
      case (ofs)
        `BMS_OFS_TOS_LOW: rd_nxt = tos[7:0];
        `BMS_OFS_TOS_HIGH: rd_nxt = {1'b0, tos[14:8]};
        `BMS_OFS_STK_PTR: rd_nxt = {3'h0, sp};
        default: rd_nxt = mem_rd;
      endcase
    end
  end
  // ========================================================
  // access sequencing
  // extra cycle for program read
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= BMS_IDLE;
    else
    begin
      case (st_r)
        BMS_IDLE: if (req && prog && !we) st_r <= BMS_PROG_WAIT;
        BMS_PROG_WAIT: st_r <= BMS_IDLE;
        default: st_r <= BMS_IDLE;
      endcase
    end
  end
  assign prog_req = (st_r == BMS_IDLE) && req && prog && !we;
  assign ack = req && (!prog || we || st_r == BMS_PROG_WAIT);
  // read data register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= `BMS_RST_BYTE;
    else if (st_r == BMS_PROG_WAIT)
      rdata <= prog_word[7:0];
    else if (req && !we && !prog)
      rdata <= rd_nxt;
  end
  // core register writes
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p0l_r <= `BMS_RST_BYTE;
      p0h_r <= `BMS_RST_BYTE;
      p1l_r <= `BMS_RST_BYTE;
      p1h_r <= `BMS_RST_BYTE;
      bank_r <= `BMS_RST_BYTE;
      work_r <= `BMS_RST_BYTE;
      pc_upper_latch_r <= `BMS_RST_BYTE;
      intctl_r <= `BMS_RST_BYTE;
      status_r <= `BMS_RST_BYTE;
      pcl_r <= `BMS_RST_BYTE;
    end
    else if (st_r == BMS_PROG_WAIT)
      work_r <= prog_word[7:0];
    // stack ops never touch upper latch
    else if (wr && ofs <= `BMS_OFS_CORE_LAST)
    begin
      case (ofs)
        `BMS_OFS_PCL: pcl_r <= wdata;
        `BMS_OFS_STATUS: status_r <= wdata;
        `BMS_OFS_P0L: p0l_r <= wdata;
        `BMS_OFS_P0H: p0h_r <= wdata;
        `BMS_OFS_P1L: p1l_r <= wdata;
        `BMS_OFS_P1H: p1h_r <= wdata;
        `BMS_OFS_BANK: bank_r <= {3'h0, wdata[4:0]};
        `BMS_OFS_WORK: work_r <= wdata;
        `BMS_OFS_PCLATCH: pc_upper_latch_r <= wdata;
        `BMS_OFS_INTCTL: intctl_r <= wdata;
        default: pcl_r <= pcl_r;
      endcase
    end
  end
  // ========================================================
  // return stack
  // push on call or interrupt
  assign op = call_push ? BMS_STK_PUSH :
    ret_pop ? BMS_STK_POP : BMS_STK_NONE;
  assign pc_ret = tos;
  logic stk_win;
  assign stk_win = wr && bank == `BMS_STK_BANK;
  bms_return_stack u_stack (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .dev_rst(dev_rst_r),
    .op(op),
    .push_pc(pc_in),
    .fault_rst_en(stack_fault_reset_enable),
    .ptr_we(stk_win && ofs == `BMS_OFS_STK_PTR),
    .ptr_wdata(wdata[4:0]),
    .tos_we_low(stk_win && ofs == `BMS_OFS_TOS_LOW),
    .tos_we_high(stk_win && ofs == `BMS_OFS_TOS_HIGH),
    .tos_wdata(wdata),
    .ptr(sp),
    .tos(tos),
    .ovf_evt(ovf_e),
    .unf_evt(unf_e),
    .fault_rst(frst)
  );
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end
    else
    begin
      ovf_r <= ovf_e | (ovf_r & ~flag_clr_ovf);
      unf_r <= unf_e | (unf_r & ~flag_clr_unf);
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      dev_rst_r <= 1'b0;
    else
      dev_rst_r <= frst;
  end
endmodule : bms_core_mem

// [sim/bms_prog_mem_model.sv]
// program memory model answering fetches of the block
// assumes the fetch address is steady in the fetch cycle
`timescale 1ns/1ps
// ====================
// program memory model
module bms_prog_mem_model (
  input wire logic sys_clk, // core clock
  input wire logic prog_req, // fetch
  input wire logic [14:0] prog_addr, // word address
  output logic [13:0] prog_word // word
);
  // word is the inverted address; idle data churns
  always_ff @(posedge sys_clk)
    prog_word <= prog_req ? ~prog_addr[13:0] : prog_word ^ 14'h2aaa;
endmodule : bms_prog_mem_model

// [sim/bms_core_mem_sva.sv]
// checker for the banked memory and return stack top
// assumes binding onto bms_core_mem, one clock domain
`timescale 1ns/1ps
module bms_core_mem_sva (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic req, // request
  input wire logic indirect, // via pointer
  input wire logic we, // write
  input wire logic ack, // done
  input wire logic [7:0] rdata, // read data
  input wire logic prog_req, // fetch
  input wire logic [13:0] prog_word, // word
  input wire logic call_push, // push
  input wire logic ret_pop, // pop
  input wire logic [14:0] pc_in, // pushed pc
  input wire logic [14:0] pc_ret, // top entry
  input wire logic [7:0] pc_upper_latch, // latch
  input wire logic [7:0] working_value, // work reg
  input wire logic stack_fault_reset_enable, // cfg
  input wire logic flag_clr_ovf, // clear
  input wire logic stack_overflow_flag, // flag
  input wire logic stack_underflow_flag, // flag
  input wire logic dev_reset_req // fault reset
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // ====================
  // properties
  property p_prog_wait;
    prog_req |-> !ack ##1 ack;
  endproperty
  a_prog_wait: assert property (p_prog_wait)
    else $error("program read ack timing wrong");
  property p_prog_byte;
    prog_req ##1 ack |=> {6'h0, rdata} == ($past(prog_word) & 14'h00ff)
      && {6'h0, working_value} == ($past(prog_word) & 14'h00ff);
  endproperty
  a_prog_byte: assert property (p_prog_byte)
    else $error("program read byte wrong");
  property p_no_prog_write;
    req && we |-> ack && !prog_req;
  endproperty
  a_no_prog_write: assert property (p_no_prog_write)
    else $error("fetch on a write");
  property p_direct_ack;
    req && !indirect |-> ack;
  endproperty
  a_direct_ack: assert property (p_direct_ack)
    else $error("direct access not acked");
  property p_latch_kept;
    (call_push || ret_pop) && !req |=> $stable(pc_upper_latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("upper latch moved on stack op");
  property p_push_top;
    call_push && !req && !stack_fault_reset_enable |=> pc_ret == $past(pc_in);
  endproperty
  a_push_top: assert property (p_push_top)
    else $error("pushed pc not on top");
  property p_ovf_sticky;
    stack_overflow_flag && !flag_clr_ovf |=> stack_overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag lost");
  property p_fault_en;
    dev_reset_req |-> $past(stack_fault_reset_enable);
  endproperty
  a_fault_en: assert property (p_fault_en)
    else $error("fault reset while disabled");
  property p_fault_pulse;
    dev_reset_req |-> (stack_overflow_flag || stack_underflow_flag)
      ##1 !dev_reset_req;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse)
    else $error("fault reset without flag or too long");
endmodule : bms_core_mem_sva
bind bms_core_mem bms_core_mem_sva chk_u (.sys_clk, .arst_n, .req,
  .indirect, .we, .ack, .rdata, .prog_req, .prog_word, .call_push,
  .ret_pop, .pc_in, .pc_ret, .pc_upper_latch, .working_value,
  .stack_fault_reset_enable, .flag_clr_ovf, .stack_overflow_flag,
  .stack_underflow_flag, .dev_reset_req);

// [sim/bms_core_mem_tb_top.sv]
// self-checking bench for the banked memory and return stack
// assumes the checker is bound and the program model sits beside
`timescale 1ns/1ps
module bms_core_mem_tb_top;
  // ====================
  // signals
  logic sys_clk = 1'h0, arst_n = 1'h0, req = 1'h0, indirect = 1'h0;
  logic ptr_sel = 1'h0, we = 1'h0, call_push = 1'h0, ret_pop = 1'h0;
  logic flag_clr_ovf = 1'h0, flag_clr_unf = 1'h0;
  logic stack_fault_reset_enable = 1'h0;
  logic [6:0] dir_ofs = 7'h0;
  logic [7:0] wdata = 8'h0, rv, rdata, pc_upper_latch, working_value;
  logic [14:0] pc_in = 15'h0, pc_ret, prog_addr;
  logic [13:0] prog_word;
  logic ack, prog_req, stack_overflow_flag, stack_underflow_flag;
  logic dev_reset_req;
  logic [7:0] interrupt_control;
  int miscompares = 0, samples_checked = 0, na, n_rst = 0;
  // clock
  always #5 sys_clk = ~sys_clk;
  bms_core_mem dut_u (.sys_clk, .arst_n, .req, .indirect, .ptr_sel,
    .dir_ofs, .we, .wdata, .ack, .rdata, .prog_req, .prog_addr,
    .prog_word, .call_push, .ret_pop, .pc_in, .pc_ret,
    .pc_upper_latch, .working_value, .interrupt_control,
    .stack_fault_reset_enable, .flag_clr_ovf, .flag_clr_unf,
    .stack_overflow_flag, .stack_underflow_flag, .dev_reset_req);
  bms_prog_mem_model pmem_u (.sys_clk, .prog_req, .prog_addr, .prog_word);
  // count fault reset pulses
  always @(posedge sys_clk)
    if (dev_reset_req === 1'h1) n_rst++;
  // ====================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic ind, input logic sel,
    input logic [6:0] ofs, input logic w, input logic [7:0] d);
    na = 0;
    @(posedge sys_clk);
    req <= 1'h1;
    indirect <= ind;
    ptr_sel <= sel;
    dir_ofs <= ofs;
    we <= w;
    wdata <= d;
    @(negedge sys_clk);
    while (ack !== 1'h1 && na < 8)
    begin
      na++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    req <= 1'h0;
    we <= 1'h0;
    @(negedge sys_clk);
    rv = rdata;
  endtask : acc
  task automatic rd(input logic [6:0] o, input logic [15:0] e);
    acc(0, 0, o, 0, 8'h0);
    chk(rv, e);
  endtask : rd
  task automatic stk(input logic push, input logic [14:0] pc);
    @(posedge sys_clk);
    call_push <= push;
    ret_pop <= !push;
    pc_in <= pc;
    @(posedge sys_clk);
    call_push <= 1'h0;
    ret_pop <= 1'h0;
    @(negedge sys_clk);
  endtask : stk
  task automatic do_reset(input logic en);
    @(posedge sys_clk);
    arst_n <= 1'h0;
    stack_fault_reset_enable <= en;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
  endtask : do_reset
  // ====================
  // scenarios
  task automatic t_banks();
    acc(0, 0, 7'h08, 1, 8'he3);
    rd(7'h08, 16'h0003);
    acc(0, 0, 7'h20, 1, 8'ha5);
    acc(0, 0, 7'h70, 1, 8'h3c);
    acc(0, 0, 7'h09, 1, 8'h96);
    acc(0, 0, 7'h08, 1, 8'h04);
    acc(0, 0, 7'h20, 1, 8'h5a);
    rd(7'h70, 16'h003c);
    rd(7'h09, 16'h0096);
    chk(working_value, 16'h0096);
    rd(7'h10, 16'h0000);
    acc(0, 0, 7'h0b, 1, 8'h80);
    rd(7'h0b, 16'h0080);
    chk(interrupt_control, 16'h0080);
    acc(0, 0, 7'h08, 1, 8'h03);
    rd(7'h20, 16'h00a5);
  endtask : t_banks
  task automatic t_indirect();
    acc(0, 0, 7'h04, 1, 8'h20);
    acc(0, 0, 7'h05, 1, 8'h01);
    acc(1, 0, 7'h0, 1, 8'hc3);
    chk(16'(na), 16'h0);
    acc(0, 0, 7'h08, 1, 8'h02);
    rd(7'h20, 16'h00c3);
    acc(0, 0, 7'h06, 1, 8'h34);
    acc(0, 0, 7'h07, 1, 8'h92);
    acc(1, 1, 7'h0, 0, 8'h0);
    chk(16'(na), 16'h1);
    chk(rv, 16'h00cb);
    chk(working_value, 16'h00cb);
    acc(0, 0, 7'h08, 1, 8'h04);
    acc(0, 0, 7'h34, 1, 8'h66);
    acc(1, 1, 7'h0, 1, 8'h11);
    rd(7'h34, 16'h0066);
    acc(1, 1, 7'h0, 0, 8'h0);
    chk(rv, 16'h00cb);
  endtask : t_indirect
  task automatic t_stack();
    acc(0, 0, 7'h08, 1, 8'h1f);
    acc(0, 0, 7'h0a, 1, 8'h5c);
    rd(7'h6d, 16'h001f);
    for (int i = 0; i < 16; i++)
    begin
      stk(1, 15'h1000 + 15'(i));
      chk(pc_ret, 16'h1000 + 16'(i));
    end
    rd(7'h6d, 16'h000f);
    chk(stack_overflow_flag, 16'h0);
    stk(1, 15'h7abc);
    chk(stack_overflow_flag, 16'h1);
    rd(7'h6d, 16'h0000);
    chk(pc_ret, 16'h7abc);
    acc(0, 0, 7'h0b, 1, 8'h00);
    chk(interrupt_control, 16'h0000);
    acc(0, 0, 7'h6d, 1, 8'h05);
    rd(7'h6e, 16'h0005);
    rd(7'h6f, 16'h0010);
    acc(0, 0, 7'h6e, 1, 8'h77);
    chk(pc_ret, 16'h1077);
    stk(0, 15'h0);
    chk(pc_ret, 16'h1004);
    rd(7'h6d, 16'h0004);
    chk(pc_upper_latch, 16'h005c);
    @(posedge sys_clk);
    flag_clr_ovf <= 1'h1;
    @(posedge sys_clk);
    flag_clr_ovf <= 1'h0;
    @(negedge sys_clk);
    chk(stack_overflow_flag, 16'h0);
  endtask : t_stack
  task automatic t_fault();
    do_reset(1'h0);
    stk(0, 15'h0);
    chk(stack_underflow_flag, 16'h1);
    @(posedge sys_clk);
    flag_clr_unf <= 1'h1;
    @(posedge sys_clk);
    flag_clr_unf <= 1'h0;
    @(negedge sys_clk);
    chk(stack_underflow_flag, 16'h0);
    do_reset(1'h1);
    for (int i = 0; i < 17; i++)
      stk(1, 15'(i));
    repeat (4) @(posedge sys_clk);
    chk(n_rst, 16'h1);
    chk(stack_overflow_flag, 16'h1);
    acc(0, 0, 7'h08, 1, 8'h1f);
    rd(7'h6d, 16'h001f);
  endtask : t_fault
  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // main sequence
  initial
  begin
    do_reset(1'h0);
    t_banks();
    t_indirect();
    t_stack();
    t_fault();
    give_verdict();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule : bms_core_mem_tb_top
